//--- verilog/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // bus and word widths
  localparam int DATA_W = 10;
  localparam int BUS_W  = 12;

  // register select field sits on the two upper bus lines
  localparam int SEL_LO_POS = 10;
  localparam int SEL_HI_POS = 11;
  localparam logic [1:0] SEL_SETUP  = 2'h0;
  localparam logic [1:0] SEL_FORMAT = 2'h1;

  // conversion_setup field positions
  localparam int REF_POS    = 0;
  localparam int PD_POS     = 2;
  localparam int PICK_LSB   = 3;
  localparam int BAL_LSB    = 5;
  localparam int SCAN_POS   = 7;
  localparam int CHECK_LSB  = 8;

  // format_and_reset_control field positions
  localparam int RESET_POS  = 0;
  localparam int SOFT_RESET_BIT_POS   = 1;
  localparam int RW_POS     = 6;
  localparam int CODING_POS = 7;
  localparam int OFFSET_POS = 8;
  localparam logic [DATA_W-1:0] FORMAT_KEEP_MASK = 10'h1c0;

  // reset values
  localparam logic [DATA_W-1:0] SETUP_RST  = 10'h020;
  localparam logic [DATA_W-1:0] FORMAT_RST = 10'h000;

  // check voltage selections
  localparam logic [1:0] CHECK_NORMAL = 2'h0;
  localparam logic [1:0] CHECK_UPPER  = 2'h1;
  localparam logic [1:0] CHECK_MID    = 2'h2;
  localparam logic [1:0] CHECK_LOWER  = 2'h3;

  // offset-binary codes at the reference points
  localparam logic [DATA_W-1:0] CODE_TOP = 10'h3ff;
  localparam logic [DATA_W-1:0] CODE_MID = 10'h200;
  localparam logic [DATA_W-1:0] CODE_BOT = 10'h000;
  // flipping the sign bit turns offset binary into two's complement
  localparam logic [DATA_W-1:0] CODING_FLIP = 10'h200;

  // bus pin vector layout and idle level
  localparam int PIN_W    = 4;
  localparam int PIN_CS0N = 0;
  localparam int PIN_CS1  = 1;
  localparam int PIN_WRN  = 2;
  localparam int PIN_RDN  = 3;
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'hd;

endpackage

//--- verilog/coder_if.sv
`timescale 1ns/100ps
interface coder_if;
  logic [adc_cfg_pkg::DATA_W-1:0] raw;
  logic                           raw_valid;
  logic [1:0]                     check_sel;
  logic                           twos;
  logic [adc_cfg_pkg::DATA_W-1:0] word;
  logic                           word_valid;

  modport main
  (
    output raw,
    output raw_valid,
    output check_sel,
    output twos,
    input  word,
    input  word_valid
  );

  modport coder
  (
    input  raw,
    input  raw_valid,
    input  check_sel,
    input  twos,
    output word,
    output word_valid
  );
endinterface

//--- verilog/result_coder.sv
`timescale 1ns/100ps
module result_coder
(
  input wire logic clk_i,
  input wire logic rstn_i,
  coder_if.coder   cif
);

  typedef struct packed {
    logic [adc_cfg_pkg::DATA_W-1:0] word;
    logic                           valid;
  } coder_s;

  coder_s st_reg;
  coder_s st_next;
  logic [adc_cfg_pkg::DATA_W-1:0] level;

  always_comb
  begin
    st_next       = st_reg;
    st_next.valid = cif.raw_valid;
    // a check selection replaces the sample by a fixed reference code
    unique case (cif.check_sel)
      adc_cfg_pkg::CHECK_UPPER:  level = adc_cfg_pkg::CODE_TOP;
      adc_cfg_pkg::CHECK_MID:    level = adc_cfg_pkg::CODE_MID;
      adc_cfg_pkg::CHECK_LOWER:  level = adc_cfg_pkg::CODE_BOT;
      default:                   level = cif.raw;
    endcase
    if (cif.raw_valid)
    begin
      if (cif.twos)
        st_next.word = level ^ adc_cfg_pkg::CODING_FLIP;
      else
        st_next.word = level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign cif.word       = st_reg.word;
  assign cif.word_valid = st_reg.valid;

endmodule

//--- verilog/adc_ctrl_regs.sv
`timescale 1ns/100ps
module adc_ctrl_regs
(
  input  wire logic                            MCLK_I,
  input  wire logic                            RSTN_I,
  input  wire logic [adc_cfg_pkg::BUS_W-1:0]   DATA_I,
  output logic      [adc_cfg_pkg::BUS_W-1:0]   DATA_O,
  output logic                                 DATA_OE_N_O,
  input  wire logic                            CS0_N_I,
  input  wire logic                            CS1_I,
  input  wire logic                            WR_N_I,
  input  wire logic                            RD_N_I,
  input  wire logic [adc_cfg_pkg::DATA_W-1:0]  SAMPLE_I,
  input  wire logic                            SAMPLE_VALID_I,
  output logic                                 REF_EXTERNAL_O,
  output logic                                 POWER_DOWN_O,
  output logic      [1:0]                      INPUT_PICK_O,
  output logic      [1:0]                      BALANCED_COUNT_O,
  output logic                                 AUTOSCAN_O,
  output logic      [1:0]                      CHECK_VOLTAGE_O,
  output logic      [2:0]                      CHANNEL_COUNT_O,
  output logic                                 CONFIG_RESERVED_O,
  output logic                                 OUTPUT_CODING_O,
  output logic                                 OFFSET_O,
  output logic                                 RW_MODE_O,
  output logic                                 SOFT_RESET_O,
  output logic                                 RESULT_VALID_O
);

  localparam int DW = adc_cfg_pkg::DATA_W;
  localparam int BW = adc_cfg_pkg::BUS_W;
  localparam int PW = adc_cfg_pkg::PIN_W;

  typedef struct packed {
    logic [PW-1:0] pin_s1;
    logic [PW-1:0] pin_s2;
    logic [PW-1:0] pin_s3;
    logic [PW-1:0] pin_filt;
    logic [BW-1:0] dat_s1;
    logic [BW-1:0] dat_s2;
    logic [BW-1:0] dat_s3;
    logic [BW-1:0] dat_filt;
    logic          wr_prev;
    logic          rd_prev;
    logic [DW-1:0] setup;
    logic [DW-1:0] format;
    logic [2:0]    chan_count;
    logic          chan_reserved;
    logic [DW-1:0] result;
    logic          result_valid;
    logic [BW-1:0] rd_word;
    logic          rd_drive;
    logic          soft_pulse;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic wr_now;
  logic rd_now;
  logic [1:0] sel;
  logic [DW-1:0] wr_value;
  logic [3:0] cfg;

  coder_if cif ();

  // channel set decode; returns {reserved, number of channels}
  function automatic logic [3:0] decode_inputs(input logic [4:0] bits);
    logic [3:0] res;
    res = 4'h8;
    unique casez (bits)
      5'b0_00_??: res = 4'h1;
      5'b0_01_0?: res = 4'h1;
      5'b1_00_01: res = 4'h2;
      5'b1_00_10: res = 4'h3;
      5'b1_00_11: res = 4'h4;
      5'b1_01_01: res = 4'h2;
      5'b1_01_10: res = 4'h3;
      5'b1_10_01: res = 4'h2;
      default:    res = 4'h8;
    endcase
    return res;
  endfunction

  always_comb
  begin
    st_next = st_reg;

    // three-stage catch of the asynchronous bus pins; a change is taken
    // once the second and third stages agree
    st_next.pin_s1 = {RD_N_I, WR_N_I, CS1_I, CS0_N_I};
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_s3 = st_reg.pin_s2;
    st_next.pin_filt = (st_reg.pin_s2 & st_reg.pin_s3)
                     | (st_reg.pin_filt & (st_reg.pin_s2 ^ st_reg.pin_s3));
    st_next.dat_s1 = DATA_I;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.dat_s3 = st_reg.dat_s2;
    st_next.dat_filt = (st_reg.dat_s2 & st_reg.dat_s3)
                     | (st_reg.dat_filt & (st_reg.dat_s2 ^ st_reg.dat_s3));

    // chip is selected with the first select low and the second high
    wr_now = !st_reg.pin_filt[adc_cfg_pkg::PIN_CS0N]
           &  st_reg.pin_filt[adc_cfg_pkg::PIN_CS1]
           & !st_reg.pin_filt[adc_cfg_pkg::PIN_WRN];
    rd_now = !st_reg.pin_filt[adc_cfg_pkg::PIN_CS0N]
           &  st_reg.pin_filt[adc_cfg_pkg::PIN_CS1]
           & !st_reg.pin_filt[adc_cfg_pkg::PIN_RDN];
    st_next.wr_prev = wr_now;
    st_next.rd_prev = rd_now;

    sel = {st_reg.dat_filt[adc_cfg_pkg::SEL_HI_POS],
           st_reg.dat_filt[adc_cfg_pkg::SEL_LO_POS]};
    wr_value = st_reg.dat_filt[DW-1:0];
    st_next.soft_pulse = 1'b0;

    // a write is taken once, on the filtered strobe's leading edge
    if (wr_now && !st_reg.wr_prev)
    begin
      unique case (sel)
        adc_cfg_pkg::SEL_SETUP:
          st_next.setup = wr_value;
        adc_cfg_pkg::SEL_FORMAT:
        begin
          // only the r/w, coding and offset bits are kept; bit 9 is spare
          st_next.format = wr_value & adc_cfg_pkg::FORMAT_KEEP_MASK;
          if (wr_value[adc_cfg_pkg::SOFT_RESET_BIT_POS])
          begin
            st_next.soft_pulse   = 1'b1;
            st_next.result       = '0;
            st_next.result_valid = 1'b0;
          end
          if (wr_value[adc_cfg_pkg::RESET_POS])
          begin
            // reset bit returns both registers to their power-up values
            st_next.setup  = adc_cfg_pkg::SETUP_RST;
            st_next.format = adc_cfg_pkg::FORMAT_RST;
          end
        end
        default:
          st_next.setup = st_reg.setup;
      endcase
    end

    // the decode follows the value the setup register is about to hold
    cfg = decode_inputs({st_next.setup[adc_cfg_pkg::SCAN_POS],
                         st_next.setup[adc_cfg_pkg::BAL_LSB +: 2],
                         st_next.setup[adc_cfg_pkg::PICK_LSB +: 2]});
    st_next.chan_reserved = cfg[3];
    st_next.chan_count    = cfg[2:0];

    if (cif.word_valid)
    begin
      st_next.result       = cif.word;
      st_next.result_valid = 1'b1;
    end

    // reads return only conversion data, never a setup value; the word is
    // frozen at the read's start so the host sees it steady
    if (rd_now && !st_reg.rd_prev)
      st_next.rd_word = {{(BW-DW){1'b0}}, st_reg.result};
    st_next.rd_drive = rd_now;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RSTN_I)
    begin
      st_reg          <= '0;
      st_reg.pin_s1   <= adc_cfg_pkg::PIN_IDLE;
      st_reg.pin_s2   <= adc_cfg_pkg::PIN_IDLE;
      st_reg.pin_s3   <= adc_cfg_pkg::PIN_IDLE;
      st_reg.pin_filt <= adc_cfg_pkg::PIN_IDLE;
      st_reg.setup    <= adc_cfg_pkg::SETUP_RST;
      st_reg.format   <= adc_cfg_pkg::FORMAT_RST;
      st_reg.chan_count <= 3'h1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // while powered down no new samples enter, but the bus stays live
  assign cif.raw       = SAMPLE_I;
  assign cif.raw_valid = SAMPLE_VALID_I
                       & !st_reg.setup[adc_cfg_pkg::PD_POS];
  assign cif.check_sel = st_reg.setup[adc_cfg_pkg::CHECK_LSB +: 2];
  assign cif.twos      = st_reg.format[adc_cfg_pkg::CODING_POS];

  result_coder u_coder
  (
    .clk_i  (MCLK_I),
    .rstn_i (RSTN_I),
    .cif    (cif.coder)
  );

  assign DATA_O            = st_reg.rd_word;
  assign DATA_OE_N_O       = !st_reg.rd_drive;
  assign REF_EXTERNAL_O    = st_reg.setup[adc_cfg_pkg::REF_POS];
  assign POWER_DOWN_O      = st_reg.setup[adc_cfg_pkg::PD_POS];
  assign INPUT_PICK_O      = st_reg.setup[adc_cfg_pkg::PICK_LSB +: 2];
  assign BALANCED_COUNT_O  = st_reg.setup[adc_cfg_pkg::BAL_LSB +: 2];
  assign AUTOSCAN_O        = st_reg.setup[adc_cfg_pkg::SCAN_POS];
  assign CHECK_VOLTAGE_O   = st_reg.setup[adc_cfg_pkg::CHECK_LSB +: 2];
  assign CHANNEL_COUNT_O   = st_reg.chan_count;
  assign CONFIG_RESERVED_O = st_reg.chan_reserved;
  assign OUTPUT_CODING_O   = st_reg.format[adc_cfg_pkg::CODING_POS];
  assign OFFSET_O          = st_reg.format[adc_cfg_pkg::OFFSET_POS];
  assign RW_MODE_O         = st_reg.format[adc_cfg_pkg::RW_POS];
  assign SOFT_RESET_O      = st_reg.soft_pulse;
  assign RESULT_VALID_O    = st_reg.result_valid;

endmodule

//--- bench/adc_ctrl_regs_sva.sv
`timescale 1ns/100ps
module adc_ctrl_regs_sva
(
  input wire logic        MCLK_I,
  input wire logic        RSTN_I,
  input wire logic [11:0] DATA_I,
  input wire logic [11:0] DATA_O,
  input wire logic        DATA_OE_N_O,
  input wire logic        CS0_N_I,
  input wire logic        CS1_I,
  input wire logic        WR_N_I,
  input wire logic        RD_N_I,
  input wire logic        SAMPLE_VALID_I,
  input wire logic        REF_EXTERNAL_O,
  input wire logic        POWER_DOWN_O,
  input wire logic [1:0]  INPUT_PICK_O,
  input wire logic [1:0]  BALANCED_COUNT_O,
  input wire logic        AUTOSCAN_O,
  input wire logic [1:0]  CHECK_VOLTAGE_O,
  input wire logic [2:0]  CHANNEL_COUNT_O,
  input wire logic        CONFIG_RESERVED_O,
  input wire logic        OUTPUT_CODING_O,
  input wire logic        OFFSET_O,
  input wire logic        RW_MODE_O,
  input wire logic        SOFT_RESET_O,
  input wire logic        RESULT_VALID_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [9:0] setup_seen;
  assign setup_seen = {CHECK_VOLTAGE_O, AUTOSCAN_O, BALANCED_COUNT_O,
                       INPUT_PICK_O, POWER_DOWN_O, 1'b0, REF_EXTERNAL_O};
  // plain helper nets so that every past value is taken of a signal
  logic [9:0] wr_val;
  logic [2:0] fmt_val;
  logic       hold_ok;
  logic       rst_act;
  logic       smp_ok;
  assign wr_val  = {DATA_I[9:2], 1'b0, DATA_I[0]};
  assign fmt_val = DATA_I[8:6];
  assign hold_ok = !WR_N_I && !DATA_I[11];
  assign rst_act = !RSTN_I;
  assign smp_ok  = SAMPLE_VALID_I && !POWER_DOWN_O;
  // five sampled edges cover the worst pin-to-register latency
  sequence setup_wr;
    (!CS0_N_I && CS1_I && !WR_N_I && DATA_I[11:10] == 2'h0) [*5];
  endsequence
  sequence format_wr;
    (!CS0_N_I && CS1_I && !WR_N_I && DATA_I[11:10] == 2'h1
     && !DATA_I[0]) [*5];
  endsequence
  sequence read_req;
    (!CS0_N_I && CS1_I && !RD_N_I) [*5];
  endsequence
  setup_load_a:
    assert property (setup_wr |=> setup_seen == $past(wr_val))
      else $error("setup outputs differ from written word");
  format_load_a:
    assert property (format_wr |=>
      {OFFSET_O, OUTPUT_CODING_O, RW_MODE_O} == $past(fmt_val))
      else $error("format outputs differ from written word");
  reset_val_a:
    assert property ($rose(RSTN_I) |-> setup_seen == 10'h020 &&
      {OFFSET_O, OUTPUT_CODING_O, RW_MODE_O} == 3'h0 && !RESULT_VALID_O)
      else $error("wrong values after reset");
  cfg_hold_a:
    assert property ($changed(setup_seen) |->
      $past(hold_ok, 4) || $past(rst_act))
      else $error("setup changed without a valid write");
  read_ans_a:
    assert property (read_req |=> !DATA_OE_N_O && DATA_O[11:10] == 2'h0)
      else $error("read not answered with a result word");
  pulse_one_a:
    assert property (SOFT_RESET_O |=> !SOFT_RESET_O && !RESULT_VALID_O)
      else $error("soft reset pulse too long or result kept");
  result_gate_a:
    assert property ($rose(RESULT_VALID_O) |->
      $past(smp_ok, 2) || $past(smp_ok, 3))
      else $error("result without an accepted sample");
  decode_rsv_a:
    assert property (CONFIG_RESERVED_O |-> CHANNEL_COUNT_O == 3'h0)
      else $error("reserved setup with nonzero count");
  decode_one_a:
    assert property (!AUTOSCAN_O && !CONFIG_RESERVED_O |->
      CHANNEL_COUNT_O == 3'h1)
      else $error("single channel mode count wrong");
endmodule

bind adc_ctrl_regs adc_ctrl_regs_sva chk (.*);

//--- bench/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model
(
  input  wire logic        clk_i,
  input  wire logic [11:0] rd_data_i,
  output logic      [11:0] data_o,
  output logic             cs0_n_o,
  output logic             cs1_o,
  output logic             wr_n_o,
  output logic             rd_n_o
);
  initial
  begin
    data_o = 12'h000;
    cs0_n_o = 1'b1;
    cs1_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
  end

  task automatic write_reg(input logic [1:0] sel, input logic [9:0] val);
    @(negedge clk_i);
    data_o = {sel, val};
    @(negedge clk_i);
    cs0_n_o = 1'b0;
    cs1_o = 1'b1;
    wr_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    wr_n_o = 1'b1;
    cs0_n_o = 1'b1;
    cs1_o = 1'b0;
    @(negedge clk_i);
    // released bus floats: show something other than the last word
    data_o = ~data_o;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic read_word(output logic [11:0] val);
    @(negedge clk_i);
    cs0_n_o = 1'b0;
    cs1_o = 1'b1;
    rd_n_o = 1'b0;
    // take the word on a falling edge, well clear of the edge that sets it
    repeat (6) @(negedge clk_i);
    val = rd_data_i;
    rd_n_o = 1'b1;
    cs0_n_o = 1'b1;
    cs1_o = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        MCLK_I, RSTN_I, DATA_OE_N_O, CS0_N_I, CS1_I, WR_N_I, RD_N_I;
  logic        SAMPLE_VALID_I, REF_EXTERNAL_O, POWER_DOWN_O, AUTOSCAN_O;
  logic        CONFIG_RESERVED_O, OUTPUT_CODING_O, OFFSET_O, RW_MODE_O;
  logic        SOFT_RESET_O, RESULT_VALID_O;
  logic [1:0]  INPUT_PICK_O, BALANCED_COUNT_O, CHECK_VOLTAGE_O;
  logic [2:0]  CHANNEL_COUNT_O;
  logic [11:0] DATA_I, DATA_O, rd_val;
  logic [9:0]  SAMPLE_I, setup_seen;
  logic [2:0]  fmt_seen;
  int          mismatches = 0, checked = 0, cycles = 0, pulses = 0, i;
  logic [4:0]  ch_cfg [9] = '{5'h00, 5'h11, 5'h12, 5'h13, 5'h19, 5'h06,
                              5'h04, 5'h15, 5'h16};
  logic [3:0]  ch_exp [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h2, 4'h8,
                              4'h1, 4'h2, 4'h3};
  logic [9:0]  bin_code [4] = '{10'h2a5, 10'h3ff, 10'h200, 10'h000};
  logic [9:0]  two_code [4] = '{10'h0a5, 10'h1ff, 10'h000, 10'h200};

  adc_ctrl_regs uut (.*);
  host_bus_model host (.clk_i(MCLK_I), .rd_data_i(DATA_O), .data_o(DATA_I),
    .cs0_n_o(CS0_N_I), .cs1_o(CS1_I), .wr_n_o(WR_N_I), .rd_n_o(RD_N_I));

  assign setup_seen = {CHECK_VOLTAGE_O, AUTOSCAN_O, BALANCED_COUNT_O,
                       INPUT_PICK_O, POWER_DOWN_O, 1'b0, REF_EXTERNAL_O};
  assign fmt_seen = {OFFSET_O, OUTPUT_CODING_O, RW_MODE_O};

  initial
  begin
    MCLK_I = 1'b0;
    forever #2 MCLK_I = ~MCLK_I;
  end

  always @(posedge MCLK_I)
  begin
    cycles++;
    if (SOFT_RESET_O === 1'b1)
      pulses++;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sample(input logic [9:0] v);
    @(negedge MCLK_I);
    SAMPLE_I = v;
    SAMPLE_VALID_I = 1'b1;
    @(negedge MCLK_I);
    SAMPLE_VALID_I = 1'b0;
    repeat (3) @(negedge MCLK_I);
  endtask

  task automatic test_done;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    RSTN_I = 1'b0;
    SAMPLE_I = 10'h000;
    SAMPLE_VALID_I = 1'b0;
    repeat (20) @(negedge MCLK_I);
    RSTN_I = 1'b1;
    chk({2'h0, setup_seen}, 12'h020);
    chk({9'h0, fmt_seen}, 12'h000);
    for (i = 0; i < 9; i++)
    begin
      host.write_reg(2'h0, {2'h0, ch_cfg[i], 3'h0});
      chk({8'h0, CONFIG_RESERVED_O, CHANNEL_COUNT_O}, {8'h0, ch_exp[i]});
    end
    // powered down until the check loop rewrites setup, yet the bus must keep working
    host.write_reg(2'h0, 10'h3fd);
    chk({2'h0, setup_seen}, 12'h3fd);
    host.write_reg(2'h1, 10'h1c0);
    chk({9'h0, fmt_seen}, 12'h007);
    host.write_reg(2'h2, 10'h000);
    host.write_reg(2'h3, 10'h000);
    chk({2'h0, setup_seen}, 12'h3fd);
    chk({9'h0, fmt_seen}, 12'h007);
    sample(10'h155);
    chk({11'h0, RESULT_VALID_O}, 12'h000);
    host.read_word(rd_val);
    chk(rd_val, 12'h000);
    // index bit 3 picks a balanced input, bit 2 the coding, bits 1:0 the check
    for (i = 0; i < 16; i++)
    begin
      host.write_reg(2'h0, {i[1:0], 2'h0, i[3], 5'h00});
      host.write_reg(2'h1, {2'h0, i[2], 7'h00});
      sample(10'h2a5);
      host.read_word(rd_val);
      chk(rd_val, {2'h0, i[2] ? two_code[i[1:0]] : bin_code[i[1:0]]});
    end
    chk({11'h0, RESULT_VALID_O}, 12'h001);
    host.write_reg(2'h1, 10'h002);
    chk(pulses[11:0], 12'h001);
    chk({11'h0, RESULT_VALID_O}, 12'h000);
    host.write_reg(2'h1, 10'h1c1);
    chk({2'h0, setup_seen}, 12'h020);
    chk({9'h0, fmt_seen}, 12'h000);
    test_done();
  end
endmodule
